// file: hw/cantx_cfg.svh
// constants of the transceiver digital control
`ifndef CANTX_CFG_SVH
`define CANTX_CFG_SVH
`define CANTX_CLK_NS 50
`define CANTX_DOM_TIMEOUT_NS 2000000
`define CANTX_DOM_CYC ((`CANTX_DOM_TIMEOUT_NS + `CANTX_CLK_NS - 1) / `CANTX_CLK_NS)
`define CANTX_MODE_DELAY_NS 10000
`define CANTX_MODE_CYC (`CANTX_MODE_DELAY_NS / `CANTX_CLK_NS)
`define CANTX_ADDR_CTRL 12'h000
`define CANTX_ADDR_STAT 12'h004
`define CANTX_ADDR_IRQ 12'h008
`define CANTX_ADDR_MASK 12'h00c
`define CANTX_CTRL_RST 32'h00000000
`define CANTX_IRQ_DOM 0
`define CANTX_IRQ_UV 1
`define CANTX_IRQ_TSD 2
`define CANTX_IRQ_REC 3
`endif

// file: hw/cantx_pkg.sv
// types of the transceiver digital control
`default_nettype none
package cantx_pkg;
	typedef enum logic [1:0] {
		CANTX_PROT = 2'b00,
		CANTX_WAIT = 2'b01,
		CANTX_RUN = 2'b10
	} cantx_mode_t;
	typedef struct packed {
		logic main_uv;
		logic logic_uv;
		logic thermal_hot;
		logic thermal_cool;
	} cantx_health_t;
	typedef struct packed {
		logic drive_dom;
		logic out_en;
		logic rxd;
	} cantx_bus_t;
endpackage
`default_nettype wire

// file: hw/cantx_domguard.sv
// dominant timeout guard on the transmit input
`include "cantx_cfg.svh"
`default_nettype none
module cantx_domguard import cantx_pkg::*; #(
	parameter int unsigned DOM_CYC = `CANTX_DOM_CYC
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic txd, // transmit request, low is dominant
	output logic tx_block, // transmitter held off after timeout
	output logic timeout_pulse // one cycle at timeout
);
	typedef struct packed {
		logic [16:0] cnt;
		logic blk;
		logic txd_prev;
		logic pulse;
	} cantx_dg_t;
	cantx_dg_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		s_d.txd_prev = txd;
		if (txd) begin
			s_d.cnt = '0;
			if (!s_q.txd_prev) begin
				s_d.blk = 1'b0;
			end
		end else if (!s_q.blk) begin
			if (s_q.cnt >= 17'(DOM_CYC - 1)) begin
				s_d.blk = 1'b1;
				s_d.pulse = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 17'h00001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{cnt: '0, blk: 1'b0, txd_prev: 1'b1, pulse: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_block = s_q.blk;
	assign timeout_pulse = s_q.pulse;

	a_block_release: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.blk && txd && !s_q.txd_prev |=> !s_q.blk) else $error("block not released");
	a_block_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.blk && !txd |=> s_q.blk) else $error("block dropped while low");
endmodule // cantx_domguard
`default_nettype wire

// file: hw/cantx_ctrl.sv
// transceiver digital control top with apb registers
`include "cantx_cfg.svh"
`default_nettype none
module cantx_ctrl import cantx_pkg::*; #(
	parameter int unsigned DOM_CYC = `CANTX_DOM_CYC, // dominant timeout in cycles
	parameter bit HAS_LOGIC_SUPPLY = 1'b1 // 0: single-supply variant
) (
	input wire logic pclk, // clock 20 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic txd, // transmit data, pull-up resolved outside
	input wire logic silent_sel, // silent select, pull-down resolved outside
	input wire cantx_health_t health, // supply and thermal monitors
	input wire logic bus_dominant, // receiver comparator, high is dominant
	output cantx_bus_t bus_out, // driver and rxd
	output logic irq // level interrupt
);
	// ******************************
	// state
	// ******************************
	typedef struct packed {
		cantx_mode_t mode;
		logic [8:0] wait_cnt;
		logic tsd;
		logic uv_prev;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic soft_silent;
		cantx_bus_t bus;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
	} cantx_st_t;
	cantx_st_t s_q, s_d;

	logic tx_block;
	logic timeout_pulse;

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == `CANTX_ADDR_CTRL) || (a == `CANTX_ADDR_STAT) ||
			(a == `CANTX_ADDR_IRQ) || (a == `CANTX_ADDR_MASK);
	endfunction

	cantx_domguard #(.DOM_CYC(DOM_CYC)) u_guard (
		.pclk(pclk),
		.presetn(presetn),
		.txd(txd),
		.tx_block(tx_block),
		.timeout_pulse(timeout_pulse)
	);

	// ******************************
	// next state
	// ******************************
	logic uv_now;
	logic silent_now;
	logic access;
	logic [3:0] ev;
	assign uv_now = health.main_uv || (HAS_LOGIC_SUPPLY && health.logic_uv);
	assign silent_now = silent_sel || s_q.soft_silent;
	assign access = psel && penable && !s_q.ready;

	always_comb begin
		s_d = s_q;
		ev = '0;
		// thermal flag with hysteresis: cleared only once cooled
		if (health.thermal_hot) begin
			s_d.tsd = 1'b1;
		end else if (health.thermal_cool) begin
			s_d.tsd = 1'b0;
		end
		s_d.uv_prev = uv_now;
		unique case (s_q.mode)
			CANTX_PROT: begin
				if (!uv_now) begin
					s_d.mode = CANTX_WAIT;
					s_d.wait_cnt = '0;
				end
			end
			CANTX_WAIT: begin
				if (uv_now) begin
					s_d.mode = CANTX_PROT;
				end else if (s_q.wait_cnt >= 9'(`CANTX_MODE_CYC - 1)) begin
					s_d.mode = CANTX_RUN;
				end else begin
					s_d.wait_cnt = s_q.wait_cnt + 9'h001;
				end
			end
			CANTX_RUN: begin
				if (uv_now) begin
					s_d.mode = CANTX_PROT;
				end
			end
			default: s_d.mode = CANTX_PROT;
		endcase
		// driver: low txd dominant only in normal run without faults
		s_d.bus.drive_dom = (s_q.mode == CANTX_RUN) && !silent_now && !tx_block &&
			!s_d.tsd && !txd && !uv_now;
		s_d.bus.out_en = (s_q.mode != CANTX_PROT) && !uv_now;
		// receiver mirrors bus in normal and silent alike
		s_d.bus.rxd = (uv_now) ? 1'b1 : !bus_dominant;
		ev[`CANTX_IRQ_DOM] = timeout_pulse;
		ev[`CANTX_IRQ_UV] = uv_now && !s_q.uv_prev;
		ev[`CANTX_IRQ_TSD] = s_d.tsd && !s_q.tsd;
		ev[`CANTX_IRQ_REC] = (s_q.mode == CANTX_WAIT) && (s_d.mode == CANTX_RUN);
		// apb
		s_d.ready = access;
		s_d.err = 1'b0;
		s_d.rdata = '0;
		if (access) begin
			s_d.err = !addr_ok(paddr);
			if (pwrite) begin
				unique case (paddr)
					`CANTX_ADDR_CTRL: s_d.soft_silent = pwdata[0];
					`CANTX_ADDR_IRQ: s_d.irq_stat = s_q.irq_stat & ~pwdata[3:0];
					`CANTX_ADDR_MASK: s_d.irq_mask = pwdata[3:0];
					default: ;
				endcase
			end else begin
				unique case (paddr)
					`CANTX_ADDR_CTRL: s_d.rdata = {31'h0, s_q.soft_silent};
					`CANTX_ADDR_STAT: s_d.rdata = {25'h0, silent_now, tx_block,
						s_q.tsd, s_q.mode == CANTX_RUN,
						uv_now, s_q.mode};
					`CANTX_ADDR_IRQ: s_d.rdata = {28'h0, s_q.irq_stat};
					`CANTX_ADDR_MASK: s_d.rdata = {28'h0, s_q.irq_mask};
					default: ;
				endcase
			end
		end
		// set wins over clear
		s_d.irq_stat = s_d.irq_stat | ev;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{mode: CANTX_PROT, wait_cnt: '0, tsd: 1'b0, uv_prev: 1'b1,
				irq_stat: '0, irq_mask: '0, soft_silent: 1'b0,
				bus: '{drive_dom: 1'b0, out_en: 1'b0, rxd: 1'b1},
				rdata: '0, ready: 1'b0, err: 1'b0, irq: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign bus_out = s_q.bus;
	assign irq = s_q.irq;

	// ******************************
	// assertion helpers
	// ******************************
	// settled cycles in the wait state, counted apart from wait_cnt so that a
	// slip in the state counter cannot vouch for itself
	logic [8:0] chk_wait_q;
	// an apb access phase whose answer is still outstanding
	logic chk_take;

	assign chk_take = psel && penable && !pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_wait_q <= '0;
		end else if (s_q.mode == CANTX_WAIT && !uv_now) begin
			chk_wait_q <= chk_wait_q + 9'h001;
		end else begin
			chk_wait_q <= '0;
		end
	end

	// ******************************
	// driver and thermal flag checks
	// ******************************
	a_silent_recessive: assert property (@(posedge pclk) disable iff (!presetn)
		silent_sel |=> !s_q.bus.drive_dom)
		else $error("driven while silent");
	a_soft_silent: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.soft_silent |=> !s_q.bus.drive_dom)
		else $error("driven while soft silent");
	a_blocked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		tx_block |=> !s_q.bus.drive_dom)
		else $error("driven while blocked");
	a_recessive_txd: assert property (@(posedge pclk) disable iff (!presetn)
		txd |=> !s_q.bus.drive_dom)
		else $error("dominant on high txd");
	a_normal_drive: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_RUN && !uv_now && !silent_now && !tx_block && !s_d.tsd && !txd
		|=> s_q.bus.drive_dom) else $error("no dominant drive");
	a_wait_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode != CANTX_RUN |=> !s_q.bus.drive_dom)
		else $error("driven before running");
	a_tsd_driver_off: assert property (@(posedge pclk) disable iff (!presetn)
		health.thermal_hot |=> !s_q.bus.drive_dom)
		else $error("driven hot");
	a_tsd_sets: assert property (@(posedge pclk) disable iff (!presetn)
		health.thermal_hot |=> s_q.tsd)
		else $error("thermal state not taken");
	a_tsd_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tsd && !health.thermal_cool |=> s_q.tsd)
		else $error("thermal state left too early");

	// ******************************
	// receive checks
	// ******************************
	a_rx_follows_bus: assert property (@(posedge pclk) disable iff (!presetn)
		!uv_now |=> s_q.bus.rxd == !$past(bus_dominant))
		else $error("rxd wrong");
	a_rx_in_silent: assert property (@(posedge pclk) disable iff (!presetn)
		silent_now && !uv_now |=> s_q.bus.rxd == !$past(bus_dominant))
		else $error("rxd lost in silent");
	a_rx_while_hot: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tsd && !uv_now |=> s_q.bus.rxd == !$past(bus_dominant))
		else $error("rxd lost while hot");
	a_uv_rxd_high: assert property (@(posedge pclk) disable iff (!presetn)
		uv_now |=> s_q.bus.rxd)
		else $error("rxd low in uv");

	// ******************************
	// mode checks
	// ******************************
	// the bound counts settled wait cycles only: a fresh uv restarts recovery
	a_uv_outputs_off: assert property (@(posedge pclk) disable iff (!presetn)
		uv_now |=> !s_q.bus.out_en && !s_q.bus.drive_dom)
		else $error("driven in uv");
	a_uv_to_prot: assert property (@(posedge pclk) disable iff (!presetn)
		uv_now |=> s_q.mode == CANTX_PROT)
		else $error("uv did not protect");
	a_prot_outputs_off: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_PROT |=> !s_q.bus.out_en)
		else $error("outputs on in protected");
	a_run_out_en: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_RUN && !uv_now |=> s_q.bus.out_en)
		else $error("outputs off while running");
	a_recover_delay: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_PROT && !uv_now |=> s_q.mode == CANTX_WAIT [*8])
		else $error("recovered too soon");
	a_recover_bound: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_WAIT |-> chk_wait_q < 9'(`CANTX_MODE_CYC))
		else $error("recovery too slow");
	a_recover_exact: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == CANTX_WAIT && s_d.mode == CANTX_RUN |-> chk_wait_q == 9'(`CANTX_MODE_CYC - 1))
		else $error("recovery delay wrong");

	// ******************************
	// register checks
	// ******************************
	// one wait state: the answer is registered, so it stands for one cycle only
	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held");
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take && !addr_ok(paddr) |=> pslverr)
		else $error("no error on unmapped");
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take && addr_ok(paddr) |=> !pslverr)
		else $error("error on mapped");
	a_idle_rdata: assert property (@(posedge pclk) disable iff (!presetn)
		!chk_take |=> prdata == 32'h00000000)
		else $error("read data outside answer");
	a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take && pwrite && paddr == `CANTX_ADDR_MASK
		|=> {28'h0000000, s_q.irq_mask} == ($past(pwdata) & 32'h0000000f)) else $error("mask lost");
	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take && pwrite && paddr == `CANTX_ADDR_CTRL
		|=> {31'h00000000, s_q.soft_silent} == ($past(pwdata) & 32'h00000001)) else $error("ctrl lost");
	a_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
		chk_take && pwrite && paddr == `CANTX_ADDR_IRQ && ev == 4'h0
		|=> ({28'h0000000, s_q.irq_stat} & $past(pwdata)) == 32'h00000000) else $error("w1c failed");
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		timeout_pulse |=> s_q.irq_stat[`CANTX_IRQ_DOM])
		else $error("timeout event lost");
	a_irq_masked_off: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.irq_mask == 4'h0 && !chk_take |=> !irq)
		else $error("irq while masked");

	// ******************************
	// coverage
	// ******************************
	c_timeout: cover property (@(posedge pclk) disable iff (!presetn) timeout_pulse);
	c_recover: cover property (@(posedge pclk) disable iff (!presetn) ev[`CANTX_IRQ_REC]);
	c_silent_rx: cover property (@(posedge pclk) disable iff (!presetn)
		silent_sel && bus_dominant);
	c_uv_entry: cover property (@(posedge pclk) disable iff (!presetn) ev[`CANTX_IRQ_UV]);
	c_block_release: cover property (@(posedge pclk) disable iff (!presetn)
		tx_block ##1 !tx_block);
endmodule // cantx_ctrl
`default_nettype wire

// file: dv/cantx_host_model.sv
// controller side model driving the transmit line
`default_nettype none
module cantx_host_model #(
	parameter int unsigned LOW_MAX = 11
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic tx_bit, // wanted txd level
	input wire logic stuck, // fault: no limit on low run
	output logic txd // to device
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned low_run;
	// ***
	// transmit line
	// ***
	// a sane controller never holds more than twelve dominant bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd <= 1'b1;
			low_run <= 0;
		end else begin
			txd <= tx_bit | (!stuck && low_run >= LOW_MAX);
			low_run <= txd ? 0 : low_run + 1;
		end
	end
endmodule // cantx_host_model
`default_nettype wire

// file: dv/tb.sv
// self-checking bench of the transceiver control
`include "cantx_cfg.svh"
`default_nettype none
module tb import cantx_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic tx_bit = 1'b1, stuck = 1'b0, silent_sel = 1'b0, bus_dominant = 1'b0;
	logic txd, pready, pslverr, irq, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	cantx_health_t health = 4'h1;
	cantx_bus_t bus_out;
	int fail_count = 0, n_tests = 0, cyc = 0;
	// silent, txd, bus dominant, then expected drive and rxd
	logic [4:0] rows [5] = '{5'h06, 5'h09, 5'h14, 5'h19, 5'h03};

	always #25 pclk = ~pclk;
	cantx_ctrl #(.DOM_CYC(20), .HAS_LOGIC_SUPPLY(1'b1)) u_cantx_ctrl (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .txd(txd), .silent_sel(silent_sel), .health(health),
		.bus_dominant(bus_dominant), .bus_out(bus_out), .irq(irq));
	cantx_host_model u_cantx_host_model (.pclk(pclk), .presetn(presetn),
		.tx_bit(tx_bit), .stuck(stuck), .txd(txd));

	// ***
	// tasks
	// ***
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("fail_count %0d n_tests %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// host stays off the bus until the mode reads running
	task automatic recover();
		repeat (50) @(posedge pclk);
		apb(1'b0, `CANTX_ADDR_STAT, 32'h0);
		chk(32'(r[3:0]), 32'h1);
		repeat (160) @(posedge pclk);
		apb(1'b0, `CANTX_ADDR_STAT, 32'h0);
		chk(32'(r[3:0]), 32'ha);
		chk(32'({e, bus_out.out_en}), 32'h1);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			wrap_up();
		end
	end

	// ***
	// stimulus and checks
	// ***
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		recover();
		for (int i = 0; i < 5; i++) begin
			silent_sel <= rows[i][4];
			tx_bit <= rows[i][3];
			bus_dominant <= rows[i][2];
			repeat (3) @(posedge pclk);
			chk(32'(bus_out.drive_dom), 32'(rows[i][1]));
			chk(32'(bus_out.rxd), 32'(rows[i][0]));
		end
		tx_bit <= 1'b1;
		stuck <= 1'b1;
		apb(1'b1, `CANTX_ADDR_IRQ, 32'hf);
		apb(1'b1, `CANTX_ADDR_MASK, 32'h1);
		tx_bit <= 1'b0;
		repeat (16) @(posedge pclk);
		tx_bit <= 1'b1;
		repeat (2) @(posedge pclk);
		tx_bit <= 1'b0;
		repeat (16) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h1);
		repeat (10) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h0);
		chk(32'(irq), 32'h1);
		apb(1'b0, `CANTX_ADDR_STAT, 32'h0);
		chk(32'(r[5]), 32'h1);
		apb(1'b1, `CANTX_ADDR_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b1, `CANTX_ADDR_MASK, 32'h1);
		apb(1'b1, `CANTX_ADDR_IRQ, 32'h1);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		tx_bit <= 1'b1;
		stuck <= 1'b0;
		repeat (3) @(posedge pclk);
		tx_bit <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h1);
		for (int k = 0; k < 2; k++) begin
			health <= (k == 0) ? 4'h9 : 4'h5;
			repeat (3) @(posedge pclk);
			chk(32'({bus_out.out_en, bus_out.drive_dom}), 32'h0);
			tx_bit <= 1'b1;
			health <= 4'h1;
			recover();
			tx_bit <= 1'b0;
		end
		health <= 4'h2;
		bus_dominant <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'({bus_out.drive_dom, bus_out.rxd}), 32'h0);
		health <= 4'h0;
		repeat (3) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h0);
		health <= 4'h1;
		repeat (3) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h1);
		apb(1'b0, `CANTX_ADDR_IRQ, 32'h0);
		chk(r, 32'h0000000e);
		apb(1'b1, `CANTX_ADDR_MASK, 32'h4);
		chk(32'(irq), 32'h1);
		apb(1'b1, `CANTX_ADDR_IRQ, 32'he);
		chk(32'(irq), 32'h0);
		tx_bit <= 1'b1;
		bus_dominant <= 1'b0;
		apb(1'b1, `CANTX_ADDR_CTRL, 32'h1);
		tx_bit <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(bus_out.drive_dom), 32'h0);
		apb(1'b0, `CANTX_ADDR_CTRL, 32'h0);
		chk(r, 32'h00000001);
		tx_bit <= 1'b1;
		apb(1'b1, `CANTX_ADDR_CTRL, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({r[30:0], e}, 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'({pready, bus_out.out_en, bus_out.rxd, irq}), 32'h2);
		presetn <= 1'b1;
		recover();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
